// ---- src/mtg_pkg.sv ----
// Constants shared by the memory traffic generator blocks.
// Assumes one clock, pclk, and an APB master on the register side.
package mtg_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FIXED_ADDR = 8'h04;
  localparam logic [7:0] OFS_FIXED_CFG = 8'h08;
  localparam logic [7:0] OFS_SEED = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PATTERN = 8'h20;
  localparam logic [7:0] OFS_SNAP = 8'h40;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_ADDR_LSB = 1;
  localparam int CTRL_INSTR_LSB = 4;
  localparam int CTRL_BL_LSB = 8;
  localparam int CFG_INSTR_LSB = 0;
  localparam int CFG_BL_LSB = 8;
  localparam logic [31:0] SEED_RESET = 32'h0000_0001;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
  localparam logic [2:0] ADDR_FIXED = 3'h1;
  localparam logic [2:0] ADDR_PRBS = 3'h2;
  localparam logic [2:0] ADDR_SEQ = 3'h3;
  localparam logic [3:0] INSTR_FIXED = 4'h1;
  localparam logic [3:0] INSTR_PRBS = 4'h2;
  localparam logic [3:0] INSTR_WR_ZERO = 4'he;
  localparam logic [3:0] INSTR_RD_ZERO = 4'hf;
  localparam logic [3:0] BL_FIXED = 4'h1;
  localparam logic [3:0] BL_PRBS = 4'h2;
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam int SNAP_BL_LSB = 32;
  localparam int SNAP_CMD_FULL_BIT = 40;
  localparam int SNAP_WR_FULL_BIT = 41;
  localparam int SNAP_RD_EMPTY_BIT = 42;
  localparam int SNAP_DATA_LSB = 64;
  localparam int PAT_WORDS = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT_RD = 3'b100
  } mtg_state_e;
endpackage : mtg_pkg

// ---- src/mtg_cmp_if.sv ----
// Carries one read-back word and its context to the checker.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface mtg_cmp_if #(parameter int W = 32);
  logic valid;
  logic [W-1:0] expected;
  logic [W-1:0] actual;
  logic [31:0] start_addr;
  logic [5:0] burst_len;
  logic cmd_full;
  logic wr_full;
  logic rd_empty;
  logic [W-1:0] cmp_data;
  logic cmp_valid;
  logic cmp_error;
  logic error;
  logic [64+2*W-1:0] snapshot;
  modport gen (output valid, expected, actual, start_addr, burst_len,
    cmd_full, wr_full, rd_empty,
    input cmp_data, cmp_valid, cmp_error, error, snapshot);
  modport chk (input valid, expected, actual, start_addr, burst_len,
    cmd_full, wr_full, rd_empty,
    output cmp_data, cmp_valid, cmp_error, error, snapshot);
endinterface : mtg_cmp_if

// ---- src/mtg_lfsr.sv ----
// 32-stage Galois LFSR feeding random addresses, commands and bursts.
// Assumes load and step are one-cycle pulses on pclk.
`timescale 1ns/10ps
module mtg_lfsr (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [31:0] seed,
  input wire logic step,
  output logic [31:0] value
);
  // An all-zero state would lock up, so a zero seed loads the reset seed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= mtg_pkg::SEED_RESET;
    end else if (load) begin
      value <= (seed == 32'h0) ? mtg_pkg::SEED_RESET : seed;
    end else if (step) begin
      value <= value[0] ? ((value >> 1) ^ mtg_pkg::LFSR_TAPS)
                        : (value >> 1);
    end
  end
endmodule : mtg_lfsr

// ---- src/mtg_cmp.sv ----
// Read-back checker: compare flag, sticky error and error snapshot.
// Assumes one valid word per cycle at most, on pclk.
`timescale 1ns/10ps
module mtg_cmp #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  mtg_cmp_if.chk cif
);
  logic mismatch;
  logic [64+2*W-1:0] next_snapshot;

  assign mismatch = cif.valid && (cif.expected != cif.actual);

  always_comb begin
    next_snapshot = '0;
    next_snapshot[31:0] = cif.start_addr;
    next_snapshot[mtg_pkg::SNAP_BL_LSB +: 6] = cif.burst_len;
    next_snapshot[mtg_pkg::SNAP_CMD_FULL_BIT] = cif.cmd_full;
    next_snapshot[mtg_pkg::SNAP_WR_FULL_BIT] = cif.wr_full;
    next_snapshot[mtg_pkg::SNAP_RD_EMPTY_BIT] = cif.rd_empty;
    next_snapshot[mtg_pkg::SNAP_DATA_LSB +: W] = cif.expected;
    next_snapshot[mtg_pkg::SNAP_DATA_LSB + W +: W] = cif.actual;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.cmp_data <= '0;
      cif.cmp_valid <= 1'b0;
      cif.cmp_error <= 1'b0;
    end else begin
      cif.cmp_data <= cif.expected;
      cif.cmp_valid <= cif.valid;
      cif.cmp_error <= mismatch;
    end
  end

  // Only the first failure is kept; later ones would hide the root cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.error <= 1'b0;
      cif.snapshot <= '0;
    end else if (mismatch && !cif.error) begin
      cif.error <= 1'b1;
      cif.snapshot <= next_snapshot;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_error_sticky: assert property (cif.error |=> cif.error)
    else $error("error dropped without reset");
  a_mismatch_flag: assert property (
    cif.valid && cif.expected != cif.actual |=> cif.cmp_error && cif.error)
    else $error("mismatch not flagged");
  a_expect_out: assert property (
    cif.valid |=> cif.cmp_valid && cif.cmp_data == $past(cif.expected))
    else $error("expected word not presented");
  a_snap_fields: assert property (
    $rose(cif.error) |-> cif.snapshot[31:0] == $past(cif.start_addr)
      && cif.snapshot[mtg_pkg::SNAP_DATA_LSB + W +: W]
         == $past(cif.actual))
    else $error("snapshot fields wrong");
  c_first_error: cover property ($rose(cif.error));
endmodule : mtg_cmp

// ---- src/mtg_top.sv ----
// Memory traffic generator: APB registers, command sequencer, checker.
// Assumes the controller interface runs on pclk and an APB master.
`timescale 1ns/10ps
module mtg_top #(
  parameter int data_port_width = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_cmd_en,
  output logic [31:0] mem_cmd_addr,
  output logic [2:0] mem_cmd_instr,
  input wire logic mem_cmd_full,
  output logic mem_wr_en,
  output logic [data_port_width-1:0] mem_wr_data,
  input wire logic mem_wr_full,
  input wire logic [data_port_width-1:0] mem_rd_data,
  input wire logic mem_rd_empty,
  output logic mem_rd_en,
  output logic [data_port_width-1:0] cmp_data,
  output logic cmp_data_valid,
  output logic cmp_error,
  output logic error,
  output logic [64+2*data_port_width-1:0] error_status
);
  localparam int W = data_port_width;
  localparam int REPS = W / 32;
  localparam int SNAP_WORDS = (64 + 2 * W) / 32;
  localparam int ADDR_SHIFT = $clog2(W / 8);
  localparam logic [31:0] ADDR_STEP = 32'(W / 8);
  localparam logic [31:0] ALIGN_MASK = ~(ADDR_STEP - 32'h1);

  if (W % 32 != 0 || W < 32 || W > 128) begin : g_bad_width
    $error("data_port_width must be 32, 64, 96 or 128");
  end

  // Register state
  logic ctrl_run;
  logic [2:0] addr_mode;
  logic [3:0] instr_mode;
  logic [3:0] bl_mode;
  logic [31:0] fixed_addr;
  logic [2:0] fixed_instr;
  logic [5:0] fixed_bl;
  logic [31:0] seed;
  logic seed_load;
  logic [31:0] pattern [mtg_pkg::PAT_WORDS];

  // Sequencer state
  mtg_pkg::mtg_state_e state;
  logic [5:0] remaining;
  logic [5:0] burst_len;
  logic [31:0] start_addr;
  logic [31:0] seq_addr;
  logic [31:0] lfsr;
  logic [31:0] next_addr;
  logic [2:0] next_instr;
  logic [5:0] next_bl;
  logic zero_mode;
  logic cmd_take;
  logic cmd_load;
  logic burst_start;
  logic rd_done;
  logic last;
  logic wr_hit;
  logic rd_setup;
  logic [7:0] snap_idx;
  logic [31:0] next_prdata;

  mtg_cmp_if #(.W(W)) cif ();

  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - mtg_pkg::OFS_SNAP;
    if (a[1:0] != 2'h0) begin
      return 1'b0;
    end else if (a == mtg_pkg::OFS_CTRL || a == mtg_pkg::OFS_FIXED_ADDR ||
        a == mtg_pkg::OFS_FIXED_CFG || a == mtg_pkg::OFS_SEED ||
        a == mtg_pkg::OFS_STATUS) begin
      return 1'b1;
    end else if (a >= mtg_pkg::OFS_PATTERN && a < mtg_pkg::OFS_SNAP) begin
      return 1'b1;
    end else begin
      return a >= mtg_pkg::OFS_SNAP && 32'(rel[7:2]) < SNAP_WORDS;
    end
  endfunction : is_mapped

  // Word index into the eight-entry pattern table
  function automatic logic [2:0] pat_index(input logic [31:0] a);
    return a[ADDR_SHIFT +: 3];
  endfunction : pat_index

  // APB slave: zero wait states, read data fetched in the setup cycle
  assign pready = psel && penable;
  assign wr_hit = psel && penable && pwrite && is_mapped(paddr);
  assign rd_setup = psel && !penable;
  assign snap_idx = (paddr - mtg_pkg::OFS_SNAP) >> 2;

  always_comb begin
    next_prdata = 32'h0;
    if (paddr == mtg_pkg::OFS_CTRL) begin
      next_prdata[mtg_pkg::CTRL_RUN_BIT] = ctrl_run;
      next_prdata[mtg_pkg::CTRL_ADDR_LSB +: 3] = addr_mode;
      next_prdata[mtg_pkg::CTRL_INSTR_LSB +: 4] = instr_mode;
      next_prdata[mtg_pkg::CTRL_BL_LSB +: 4] = bl_mode;
    end else if (paddr == mtg_pkg::OFS_FIXED_ADDR) begin
      next_prdata = fixed_addr;
    end else if (paddr == mtg_pkg::OFS_FIXED_CFG) begin
      next_prdata[mtg_pkg::CFG_INSTR_LSB +: 3] = fixed_instr;
      next_prdata[mtg_pkg::CFG_BL_LSB +: 6] = fixed_bl;
    end else if (paddr == mtg_pkg::OFS_SEED) begin
      next_prdata = seed;
    end else if (paddr == mtg_pkg::OFS_STATUS) begin
      next_prdata[0] = error;
      next_prdata[1] = state != mtg_pkg::ST_IDLE;
    end else if (paddr >= mtg_pkg::OFS_PATTERN &&
        paddr < mtg_pkg::OFS_SNAP) begin
      next_prdata = pattern[paddr[4:2]];
    end else if (is_mapped(paddr)) begin
      next_prdata = error_status[snap_idx * 32 +: 32];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0 : next_prdata;
      pslverr <= !is_mapped(paddr);
    end
  end

  // Software-written registers; a seed write reloads the LFSR
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_run <= 1'b0;
      addr_mode <= mtg_pkg::ADDR_PRBS;
      instr_mode <= mtg_pkg::INSTR_PRBS;
      bl_mode <= mtg_pkg::BL_PRBS;
      fixed_addr <= 32'h0;
      fixed_instr <= mtg_pkg::CMD_WRITE;
      fixed_bl <= 6'h1;
      seed <= mtg_pkg::SEED_RESET;
      seed_load <= 1'b0;
      for (int i = 0; i < mtg_pkg::PAT_WORDS; i++) begin
        pattern[i] <= 32'h0;
      end
    end else begin
      seed_load <= wr_hit && paddr == mtg_pkg::OFS_SEED;
      if (wr_hit && paddr == mtg_pkg::OFS_CTRL) begin
        ctrl_run <= pwdata[mtg_pkg::CTRL_RUN_BIT];
        addr_mode <= pwdata[mtg_pkg::CTRL_ADDR_LSB +: 3];
        instr_mode <= pwdata[mtg_pkg::CTRL_INSTR_LSB +: 4];
        bl_mode <= pwdata[mtg_pkg::CTRL_BL_LSB +: 4];
      end else if (wr_hit && paddr == mtg_pkg::OFS_FIXED_ADDR) begin
        fixed_addr <= pwdata;
      end else if (wr_hit && paddr == mtg_pkg::OFS_FIXED_CFG) begin
        fixed_instr <= pwdata[mtg_pkg::CFG_INSTR_LSB +: 3];
        fixed_bl <= pwdata[mtg_pkg::CFG_BL_LSB +: 6];
      end else if (wr_hit && paddr == mtg_pkg::OFS_SEED) begin
        seed <= pwdata;
      end else if (wr_hit && paddr >= mtg_pkg::OFS_PATTERN &&
          paddr < mtg_pkg::OFS_SNAP) begin
        pattern[paddr[4:2]] <= pwdata;
      end
    end
  end

  mtg_lfsr u_lfsr (
    .pclk(pclk),
    .presetn(presetn),
    .load(seed_load),
    .seed(seed),
    .step(cmd_load),
    .value(lfsr)
  );

  // Next command choice; any unassigned mode code falls back to random
  assign zero_mode = instr_mode == mtg_pkg::INSTR_WR_ZERO ||
                     instr_mode == mtg_pkg::INSTR_RD_ZERO;

  always_comb begin
    next_instr = lfsr[31] ? mtg_pkg::CMD_READ : mtg_pkg::CMD_WRITE;
    if (instr_mode == mtg_pkg::INSTR_FIXED) begin
      next_instr = fixed_instr;
    end else if (instr_mode == mtg_pkg::INSTR_WR_ZERO) begin
      next_instr = mtg_pkg::CMD_WRITE;
    end else if (instr_mode == mtg_pkg::INSTR_RD_ZERO) begin
      next_instr = mtg_pkg::CMD_READ;
    end
    next_addr = lfsr & ALIGN_MASK;
    if (zero_mode) begin
      next_addr = 32'h0;
    end else if (addr_mode == mtg_pkg::ADDR_FIXED) begin
      next_addr = fixed_addr;
    end else if (addr_mode == mtg_pkg::ADDR_SEQ) begin
      next_addr = seq_addr;
    end
    next_bl = lfsr[13:8];
    if (bl_mode == mtg_pkg::BL_FIXED) begin
      next_bl = fixed_bl;
    end
    // A zero burst would wrap the count and run 64 commands, so it issues one command
    if (next_bl == 6'h0) begin
      next_bl = 6'h1;
    end
  end

  // Command leaves only when every needed queue has room
  assign cmd_take = mem_cmd_en && !mem_cmd_full &&
                    !(mem_wr_en && mem_wr_full);
  assign rd_done = state == mtg_pkg::ST_WAIT_RD && !mem_rd_empty;
  assign last = remaining == 6'h1;
  assign burst_start = state == mtg_pkg::ST_IDLE && ctrl_run;
  assign cmd_load = burst_start ||
    (state == mtg_pkg::ST_ISSUE && cmd_take &&
     mem_cmd_instr != mtg_pkg::CMD_READ && !last) ||
    (rd_done && !last);
  assign mem_rd_en = state == mtg_pkg::ST_WAIT_RD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mtg_pkg::ST_IDLE;
    end else begin
      case (state)
        mtg_pkg::ST_IDLE: begin
          if (ctrl_run) begin
            state <= mtg_pkg::ST_ISSUE;
          end
        end
        mtg_pkg::ST_ISSUE: begin
          if (cmd_take && mem_cmd_instr == mtg_pkg::CMD_READ) begin
            state <= mtg_pkg::ST_WAIT_RD;
          end else if (cmd_take && last) begin
            state <= mtg_pkg::ST_IDLE;
          end
        end
        mtg_pkg::ST_WAIT_RD: begin
          if (rd_done) begin
            state <= last ? mtg_pkg::ST_IDLE : mtg_pkg::ST_ISSUE;
          end
        end
        default: begin
          state <= mtg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Burst bookkeeping: the count includes the command in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= 6'h0;
      burst_len <= 6'h0;
      start_addr <= 32'h0;
    end else if (burst_start) begin
      remaining <= next_bl;
      burst_len <= next_bl;
      start_addr <= next_addr;
    end else if (cmd_load) begin
      remaining <= remaining - 6'h1;
    end
  end

  // Held unchanged while the controller refuses them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_cmd_en <= 1'b0;
      mem_cmd_addr <= 32'h0;
      mem_cmd_instr <= mtg_pkg::CMD_WRITE;
      mem_wr_en <= 1'b0;
      mem_wr_data <= '0;
    end else if (cmd_load) begin
      mem_cmd_en <= 1'b1;
      mem_cmd_addr <= next_addr;
      mem_cmd_instr <= next_instr;
      mem_wr_en <= next_instr == mtg_pkg::CMD_WRITE;
      mem_wr_data <= {REPS{pattern[pat_index(next_addr)]}};
    end else if (cmd_take) begin
      mem_cmd_en <= 1'b0;
      mem_wr_en <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_addr <= 32'h0;
    end else if (state == mtg_pkg::ST_IDLE && !ctrl_run) begin
      seq_addr <= fixed_addr & ALIGN_MASK;
    end else if (cmd_load && !zero_mode &&
        addr_mode == mtg_pkg::ADDR_SEQ) begin
      seq_addr <= seq_addr + ADDR_STEP;
    end
  end

  // Only one read is outstanding, so its address names the expected word
  assign cif.valid = rd_done;
  assign cif.expected = {REPS{pattern[pat_index(mem_cmd_addr)]}};
  assign cif.actual = mem_rd_data;
  assign cif.start_addr = start_addr;
  assign cif.burst_len = burst_len;
  assign cif.cmd_full = mem_cmd_full;
  assign cif.wr_full = mem_wr_full;
  assign cif.rd_empty = mem_rd_empty;

  mtg_cmp #(.W(W)) u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.chk)
  );

  assign cmp_data = cif.cmp_data;
  assign cmp_data_valid = cif.cmp_valid;
  assign cmp_error = cif.cmp_error;
  assign error = cif.error;
  assign error_status = cif.snapshot;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fixed_addr: assert property (
    cmd_load && !zero_mode && addr_mode == mtg_pkg::ADDR_FIXED
    |=> mem_cmd_addr == $past(fixed_addr))
    else $error("fixed address not used");
  a_seq_step: assert property (
    cmd_load && !zero_mode && addr_mode == mtg_pkg::ADDR_SEQ
    && !(state == mtg_pkg::ST_IDLE && !ctrl_run)
    |=> seq_addr == $past(seq_addr) + ADDR_STEP)
    else $error("sequential step wrong");
  a_fixed_instr: assert property (
    cmd_load && instr_mode == mtg_pkg::INSTR_FIXED
    |=> mem_cmd_instr == $past(fixed_instr))
    else $error("fixed instruction not used");
  a_zero_write: assert property (
    cmd_load && instr_mode == mtg_pkg::INSTR_WR_ZERO
    |=> mem_cmd_addr == 32'h0 && mem_cmd_instr == mtg_pkg::CMD_WRITE
        && mem_wr_en)
    else $error("write-zero mode wrong");
  a_fixed_burst: assert property (
    burst_start && bl_mode == mtg_pkg::BL_FIXED && fixed_bl != 6'h0
    |=> burst_len == $past(fixed_bl) && remaining == $past(fixed_bl))
    else $error("fixed burst length not used");
  a_hold_full: assert property (
    mem_cmd_en && mem_cmd_full |=> mem_cmd_en && $stable(mem_cmd_addr)
      && $stable(mem_cmd_instr))
    else $error("command changed while queue full");
  c_write_take: cover property (
    cmd_take && mem_cmd_instr == mtg_pkg::CMD_WRITE);
  c_read_back: cover property (rd_done ##1 cmp_data_valid);
  c_full_stall: cover property (mem_cmd_en && mem_cmd_full ##1 cmd_take);
endmodule : mtg_top

// ---- test/mtg_mem_model.sv ----
// Behavioural memory controller on the native command and data side.
// Assumes pclk, W = 32, one read outstanding; stall slows every answer.
`timescale 1ns/10ps
module mtg_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic corrupt,
  input wire logic cmd_en,
  input wire logic [31:0] cmd_addr,
  input wire logic [2:0] cmd_instr,
  output logic cmd_full,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output logic wr_full,
  output logic [31:0] rd_data,
  output logic rd_empty,
  input wire logic rd_en
);
  logic [31:0] mem [logic [31:0]];
  logic [2:0] tick;
  logic [3:0] wait_cnt;
  logic [31:0] rd_addr;
  logic take;
  assign take = cmd_en && !cmd_full && !(wr_en && wr_full);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 3'h0;
      wait_cnt <= 4'h0;
      cmd_full <= 1'b0;
      wr_full <= 1'b0;
      rd_empty <= 1'b1;
      rd_data <= 32'h0;
    end else begin
      tick <= tick + 3'h1;
      cmd_full <= stall && tick[1];
      wr_full <= stall && tick[2];
      if (take && cmd_instr == 3'h0 && wr_en) begin
        mem[cmd_addr] = wr_data;
      end
      if (take && cmd_instr == 3'h1) begin
        wait_cnt <= stall ? 4'h6 : 4'h2;
        rd_addr <= cmd_addr;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      // Unwritten places read as zero; corrupt flips bit 0 on purpose
      if (wait_cnt == 4'h1) begin
        rd_empty <= 1'b0;
        rd_data <= (mem.exists(rd_addr) ? mem[rd_addr] : 32'h0) ^ 32'(corrupt);
      end else if (rd_en && !rd_empty) begin
        rd_empty <= 1'b1;
        rd_data <= ~rd_data;
      end
    end
  end
endmodule : mtg_mem_model

// ---- test/testbench.sv ----
// Self-checking bench for the traffic generator with W = 32.
// Assumes mtg_mem_model as the controller; APB master is this bench.
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_cmd_addr, mem_wr_data, mem_rd_data;
  logic mem_cmd_en, mem_cmd_full, mem_wr_en, mem_wr_full, mem_rd_empty;
  logic mem_rd_en, cmp_data_valid, cmp_error, error, stall, corrupt;
  logic [2:0] mem_cmd_instr;
  logic [31:0] cmp_data;
  logic [127:0] error_status;
  int failures, compares;
  logic [31:0] addr_q[$], data_q[$], cmp_q[$], pat[8];
  logic [2:0] instr_q[$];
  logic cerr_q[$];
  mtg_top #(.data_port_width(32)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_cmd_en(mem_cmd_en), .mem_cmd_addr(mem_cmd_addr),
    .mem_cmd_instr(mem_cmd_instr), .mem_cmd_full(mem_cmd_full),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .mem_wr_full(mem_wr_full), .mem_rd_data(mem_rd_data),
    .mem_rd_empty(mem_rd_empty), .mem_rd_en(mem_rd_en),
    .cmp_data(cmp_data), .cmp_data_valid(cmp_data_valid),
    .cmp_error(cmp_error), .error(error), .error_status(error_status));
  mtg_mem_model mem (.pclk(pclk), .presetn(presetn), .stall(stall),
    .corrupt(corrupt), .cmd_en(mem_cmd_en), .cmd_addr(mem_cmd_addr),
    .cmd_instr(mem_cmd_instr), .cmd_full(mem_cmd_full),
    .wr_en(mem_wr_en), .wr_data(mem_wr_data), .wr_full(mem_wr_full),
    .rd_data(mem_rd_data), .rd_empty(mem_rd_empty), .rd_en(mem_rd_en));
  // Logs every taken command and every compared word
  always @(posedge pclk) begin
    if (presetn && mem_cmd_en && !mem_cmd_full &&
        !(mem_wr_en && mem_wr_full)) begin
      addr_q.push_back(mem_cmd_addr);
      instr_q.push_back(mem_cmd_instr);
      data_q.push_back(mem_wr_data);
    end
    if (presetn && cmp_data_valid) begin
      cmp_q.push_back(cmp_data);
      cerr_q.push_back(cmp_error);
    end
  end
  task automatic check(input logic [127:0] s, input logic [127:0] x,
      input string m);
    compares += 1;
    if (s !== x) begin
      failures += 1;
      $display("wrong value at %0t: %s got %0h want %0h", $time, m, s, x);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One burst: load modes, pulse run, then poll busy until idle
  task automatic go(input logic [2:0] am, input logic [3:0] im,
      input logic [3:0] bm, input logic [2:0] fi, input logic [5:0] fb,
      input logic [31:0] fa);
    logic [31:0] q;
    logic e;
    addr_q.delete();
    instr_q.delete();
    data_q.delete();
    cmp_q.delete();
    cerr_q.delete();
    apb(1'b1, mtg_pkg::OFS_FIXED_ADDR, fa, q, e);
    apb(1'b1, mtg_pkg::OFS_FIXED_CFG, {18'h0, fb, 5'h0, fi}, q, e);
    apb(1'b1, mtg_pkg::OFS_CTRL, {20'h0, bm, im, am, 1'b1}, q, e);
    apb(1'b1, mtg_pkg::OFS_CTRL, {20'h0, bm, im, am, 1'b0}, q, e);
    do apb(1'b0, mtg_pkg::OFS_STATUS, 32'h0, q, e); while (q[1] !== 1'b0);
    repeat (2) @(posedge pclk);
  endtask : go
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'b0, mtg_pkg::OFS_CTRL, 32'h0, q, e);
    check(q, 32'h224, "ctrl reset");
    apb(1'b0, mtg_pkg::OFS_SEED, 32'h0, q, e);
    check(q, 32'h1, "seed reset");
    apb(1'b0, mtg_pkg::OFS_FIXED_CFG, 32'h0, q, e);
    check(q, 32'h100, "cfg reset");
    apb(1'b0, 8'h18, 32'h0, q, e);
    check(e, 1'b1, "unmapped");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, mtg_pkg::OFS_PATTERN + 8'(4 * i), pat[i], q, e);
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_fixed;
    stall <= 1'b1;
    go(3'h1, 4'h1, 4'h1, mtg_pkg::CMD_WRITE, 6'd5, 32'h1000_0044);
    check(addr_q.size(), 5, "burst count");
    foreach (addr_q[i]) begin
      check(addr_q[i], 32'h1000_0044, "fixed addr");
      check(instr_q[i], 3'h0, "fixed instr");
      check(data_q[i], pat[1], "pattern word");
    end
    $display("test fixed done");
  endtask : t_fixed
  task automatic t_seq;
    stall <= 1'b0;
    go(3'h3, 4'h1, 4'h1, mtg_pkg::CMD_WRITE, 6'd8, 32'h100);
    check(addr_q.size(), 8, "write count");
    foreach (addr_q[i]) begin
      check(addr_q[i], 32'h100 + 32'(4 * i), "seq addr");
      check(data_q[i], pat[i], "seq data");
    end
    stall <= 1'b1;
    go(3'h3, 4'h1, 4'h1, mtg_pkg::CMD_READ, 6'd8, 32'h100);
    check(cmp_q.size(), 8, "compare count");
    foreach (cmp_q[i]) begin
      check(instr_q[i], 3'h1, "read instr");
      check(cmp_q[i], pat[i], "expected word");
      check(cerr_q[i], 1'b0, "no mismatch");
    end
    check(error, 1'b0, "error low");
    $display("test seq done");
  endtask : t_seq
  task automatic t_zero;
    go(3'h1, 4'he, 4'h1, mtg_pkg::CMD_READ, 6'd2, 32'h200);
    check({addr_q[1], instr_q[1]}, 35'h0, "write zero");
    go(3'h1, 4'hf, 4'h1, mtg_pkg::CMD_WRITE, 6'd2, 32'h200);
    check({addr_q[1], instr_q[1]}, 35'h1, "read zero");
    check({cmp_q[1], cerr_q[1]}, {pat[0], 1'b0}, "zero data");
    $display("test zero done");
  endtask : t_zero
  task automatic t_rand;
    logic [1:0] kinds;
    logic [31:0] a0, q;
    logic e;
    kinds = 2'b00;
    a0 = 32'h0;
    for (int k = 0; k < 2; k++) begin
      // Same seed each pass, so both passes must start alike
      apb(1'b1, mtg_pkg::OFS_SEED, 32'h1234_5678, q, e);
      go(k ? 3'h7 : 3'h2, 4'h1, 4'h1, mtg_pkg::CMD_WRITE, 6'd6, 32'h0);
      if (k == 0) a0 = addr_q[0];
      else check(addr_q[0], a0, "seed repeats");
      check(addr_q[0] != addr_q[5], 1'b1, "addr varies");
      check(addr_q[3][1:0], 2'b00, "addr aligned");
      go(3'h1, 4'h1, k ? 4'h9 : 4'h2, mtg_pkg::CMD_WRITE, 6'd1, 32'h0);
      check(addr_q.size() inside {[1:63]}, 1'b1, "rand burst");
      go(3'h1, k ? 4'h5 : 4'h2, 4'h1, mtg_pkg::CMD_WRITE, 6'd8, 32'h100);
      foreach (instr_q[i]) kinds[instr_q[i][0]] = 1'b1;
    end
    check(kinds, 2'b11, "mixed instr");
    check(error, 1'b0, "reads match");
    $display("test rand done");
  endtask : t_rand
  task automatic t_err;
    logic [31:0] q;
    logic e;
    corrupt <= 1'b1;
    stall <= 1'b0;
    go(3'h1, 4'h1, 4'h1, mtg_pkg::CMD_READ, 6'd1, 32'h104);
    check(cerr_q[0], 1'b1, "cmp error");
    check(error, 1'b1, "error set");
    check(error_status[31:0], 32'h104, "snap addr");
    check(error_status[39:32], 8'h01, "snap burst");
    check(error_status[42:40], 3'b000, "snap flags");
    check(error_status[127:64], {pat[1] ^ 32'h1, pat[1]}, "snap");
    apb(1'b0, mtg_pkg::OFS_SNAP, 32'h0, q, e);
    check(q, 32'h104, "snap read");
    corrupt <= 1'b0;
    go(3'h1, 4'h1, 4'h1, mtg_pkg::CMD_READ, 6'd1, 32'h108);
    check(cerr_q[0], 1'b0, "good word");
    check(error, 1'b1, "error sticky");
    check(error_status[31:0], 32'h104, "first kept");
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(error, 1'b0, "reset clears error");
    check(error_status, 128'h0, "reset clears snap");
    $display("test error done");
  endtask : t_err
  task results;
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, stall, corrupt} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    failures = 0;
    compares = 0;
    foreach (pat[i]) pat[i] = 32'h5ac3_e100 + 32'(i * 17);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fixed();
    t_seq();
    t_zero();
    t_rand();
    t_err();
    results();
  end
  // Whole run needs well under 10k cycles
  initial begin
    repeat (50000) @(posedge pclk);
    failures += 1;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end
endmodule : testbench
